/* File: rtl/signal_strength_monitor.sv */
// received strength monitor: per-bit measure, packet latch, threshold, jump detect
// assumes chanPower comes from the channel filter on ref_clk; bitClk is an async pin
`timescale 1ns/1ps
`include "ssm_params.svh"

module signal_strength_monitor
  import ssm_pkg::*;
#(
  parameter int NGPIO = 4,
  parameter int HDEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // modem side
  input wire logic [7:0] chanPower,
  input wire logic bitClk,
  input wire logic rxActive,
  input wire logic preambleDet,
  input wire logic syncDet,
  // notifications
  output logic [NGPIO-1:0] gpioOut,
  output logic aboveIrq,
  output logic jumpIrq,
  output logic rxRestart
);

  localparam int QUERY_CYC = (`SSM_QUERY_NS + `SSM_CLK_NS - 1) / `SSM_CLK_NS;

  // ==========================================================
  // register bus
  logic awHave_r, awHave_nxt, wHave_r, wHave_nxt, bValid_r, bValid_nxt;
  logic [7:0] awAddr_r, awAddr_nxt;
  logic [31:0] wData_r, wData_nxt, rData_r, rData_nxt;
  logic [3:0] wStrb_r, wStrb_nxt;
  logic [1:0] bResp_r, bResp_nxt, rResp_r, rResp_nxt;
  logic rValid_r, rValid_nxt;
  logic wrFire;
  logic [31:0] rdWord;
  logic rdHit;

  // config state
  ssm_cfg_t cfg_r, cfg_nxt;
  logic [7:0] thresh_r, thresh_nxt, step_r, step_nxt, trim_r, trim_nxt;
  logic [3:0] window_r, window_nxt;
  logic [2*NGPIO-1:0] pinSel_r, pinSel_nxt;
  logic [7:0] slotSel_r, slotSel_nxt;
  logic queryGo;
  logic [2:0] stClr;

  // measurement state
  logic bitS1_r, bitS2_r, bitS3_r, rxPrev_r;
  logic [7:0] strength_r, strength_nxt, latched_r, latched_nxt, bitCnt_r, bitCnt_nxt;
  logic [9:0] acc_r, acc_nxt;
  logic [1:0] phase_r, phase_nxt;
  logic latchDone_r, latchDone_nxt, pend_r, pend_nxt, upd;
  logic above_r, above_nxt, aboveLat_r, aboveLat_nxt, jumpSeen_r, jumpSeen_nxt;
  logic jumpEvt_r, jumpEvt_nxt, rstOut_r, rstOut_nxt;
  logic [7:0] hist_r [HDEPTH], hist_nxt [HDEPTH];
  logic [3:0] histCnt_r, histCnt_nxt;
  logic [NGPIO-1:0] gpio_r, gpio_nxt;
  ssm_query_state_t qState_r, qState_nxt;
  logic [15:0] qResp_r, qResp_nxt;
  logic [11:0] qCnt_r, qCnt_nxt;
  logic bitTick, rxStart, trig;
  logic [7:0] minBits, old;
  logic [3:0] win;

  assign bitTick = bitS2_r & ~bitS3_r & rxActive;
  assign rxStart = rxActive & ~rxPrev_r;
  assign wrFire = awHave_r & wHave_r & ~bValid_r;

  function automatic logic [31:0] merge(logic [31:0] old32, logic [31:0] d, logic [3:0] s);
    logic [31:0] r;
    r = old32;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] slotVal(logic [1:0] src, logic [7:0] cur, logic [7:0] lat,
                                         logic [7:0] st);
    case (src)
      SSM_SRC_LATCHED: slotVal = lat;
      SSM_SRC_CURRENT: slotVal = cur;
      SSM_SRC_STATUS:  slotVal = st;
      default:         slotVal = 8'h00;
    endcase
  endfunction

  // read mux
  always_comb begin
    logic [7:0] st;
    st = {3'b000, latchDone_r, qState_r == SSM_Q_IDLE, jumpSeen_r, aboveLat_r, above_r};
    rdHit = 1'b1;
    rdWord = 32'h0000_0000;
    case (s_axi_araddr)
      `SSM_OFF_CONFIG: begin
        rdWord[`SSM_CFG_MODE_LSB +: 2] = cfg_r.latchMode;
        rdWord[`SSM_CFG_AVG_BIT] = cfg_r.avg4;
        rdWord[`SSM_CFG_BITS_LSB +: 8] = cfg_r.latchBits;
        rdWord[`SSM_CFG_UP_BIT] = cfg_r.jumpUp;
        rdWord[`SSM_CFG_DN_BIT] = cfg_r.jumpDn;
        rdWord[`SSM_CFG_RST_BIT] = cfg_r.jumpRst;
      end
      `SSM_OFF_THRESH: rdWord[7:0] = thresh_r;
      `SSM_OFF_STEP: rdWord[7:0] = step_r;
      `SSM_OFF_WINDOW: rdWord[3:0] = window_r;
      `SSM_OFF_TRIM: rdWord[7:0] = trim_r;
      `SSM_OFF_GPIOSEL: rdWord[2*NGPIO-1:0] = pinSel_r;
      `SSM_OFF_CURRENT: rdWord[7:0] = strength_r;
      `SSM_OFF_LATCHED: rdWord[7:0] = latched_r;
      `SSM_OFF_STATUS: rdWord[7:0] = st;
      `SSM_OFF_SLOTSEL: rdWord[7:0] = slotSel_r;
      `SSM_OFF_RESP: rdWord[15:0] = qResp_r;
      default: begin
        rdHit = 1'b0;
        for (int k = 0; k < 4; k++) begin
          if (s_axi_araddr == `SSM_OFF_SLOT0 + 8'(4 * k)) begin
            rdHit = 1'b1;
            rdWord[7:0] = slotVal(slotSel_r[2*k +: 2], strength_r, latched_r, st);
          end
        end
      end
    endcase
  end

  // bus next state, one write and one read outstanding
  always_comb begin
    awHave_nxt = awHave_r;
    wHave_nxt = wHave_r;
    awAddr_nxt = awAddr_r;
    wData_nxt = wData_r;
    wStrb_nxt = wStrb_r;
    bValid_nxt = bValid_r & ~s_axi_bready;
    bResp_nxt = bResp_r;
    rValid_nxt = rValid_r & ~s_axi_rready;
    rData_nxt = rData_r;
    rResp_nxt = rResp_r;
    if (s_axi_awvalid && !awHave_r) begin
      awHave_nxt = 1'b1;
      awAddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHave_r) begin
      wHave_nxt = 1'b1;
      wData_nxt = s_axi_wdata;
      wStrb_nxt = s_axi_wstrb;
    end
    if (wrFire) begin
      awHave_nxt = 1'b0;
      wHave_nxt = 1'b0;
      bValid_nxt = 1'b1;
      bResp_nxt = (awAddr_r <= `SSM_OFF_RESP && awAddr_r[1:0] == 2'b00) ? 2'b00 : 2'b10;
    end
    if (s_axi_arvalid && !rValid_r) begin
      rValid_nxt = 1'b1;
      rData_nxt = rdWord;
      rResp_nxt = rdHit ? 2'b00 : 2'b10;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      bValid_r <= 1'b0;
      bResp_r <= 2'b00;
      rValid_r <= 1'b0;
      rData_r <= 32'h0000_0000;
      rResp_r <= 2'b00;
    end else begin
      awHave_r <= awHave_nxt;
      wHave_r <= wHave_nxt;
      awAddr_r <= awAddr_nxt;
      wData_r <= wData_nxt;
      wStrb_r <= wStrb_nxt;
      bValid_r <= bValid_nxt;
      bResp_r <= bResp_nxt;
      rValid_r <= rValid_nxt;
      rData_r <= rData_nxt;
      rResp_r <= rResp_nxt;
    end
  end

  assign s_axi_awready = ~awHave_r;
  assign s_axi_wready = ~wHave_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = ~rValid_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

  // ==========================================================
  // configuration registers
  always_comb begin
    logic [31:0] w;
    w = 32'h0000_0000;
    cfg_nxt = cfg_r;
    thresh_nxt = thresh_r;
    step_nxt = step_r;
    window_nxt = window_r;
    trim_nxt = trim_r;
    pinSel_nxt = pinSel_r;
    slotSel_nxt = slotSel_r;
    queryGo = 1'b0;
    stClr = 3'b000;
    if (wrFire) begin
      w = merge(32'h0000_0000, wData_r, wStrb_r);
      case (awAddr_r)
        `SSM_OFF_CONFIG: begin
          w = merge({13'h0000, cfg_r.jumpRst, cfg_r.jumpDn, cfg_r.jumpUp, cfg_r.latchBits,
                     5'h00, cfg_r.avg4, cfg_r.latchMode}, wData_r, wStrb_r);
          cfg_nxt.latchMode = ssm_latch_mode_t'(w[`SSM_CFG_MODE_LSB +: 2]);
          cfg_nxt.avg4 = w[`SSM_CFG_AVG_BIT];
          cfg_nxt.latchBits = w[`SSM_CFG_BITS_LSB +: 8];
          cfg_nxt.jumpUp = w[`SSM_CFG_UP_BIT];
          cfg_nxt.jumpDn = w[`SSM_CFG_DN_BIT];
          cfg_nxt.jumpRst = w[`SSM_CFG_RST_BIT];
        end
        `SSM_OFF_THRESH: thresh_nxt = wStrb_r[0] ? wData_r[7:0] : thresh_r;
        `SSM_OFF_STEP: step_nxt = wStrb_r[0] ? wData_r[7:0] : step_r;
        `SSM_OFF_WINDOW: window_nxt = wStrb_r[0] ? wData_r[3:0] : window_r;
        `SSM_OFF_TRIM: trim_nxt = wStrb_r[0] ? wData_r[7:0] : trim_r;
        `SSM_OFF_GPIOSEL: pinSel_nxt = wStrb_r[0] ? wData_r[2*NGPIO-1:0] : pinSel_r;
        `SSM_OFF_SLOTSEL: slotSel_nxt = wStrb_r[0] ? wData_r[7:0] : slotSel_r;
        `SSM_OFF_STATUS: stClr = w[`SSM_ST_JUMP_BIT:`SSM_ST_ABOVE_BIT];
        `SSM_OFF_QUERY: queryGo = 1'b1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_r <= '{jumpRst: 1'b0, jumpDn: 1'b0, jumpUp: 1'b0, latchBits: `SSM_RST_BITS,
                 avg4: 1'b0, latchMode: SSM_LATCH_PREAMBLE};
      thresh_r <= `SSM_RST_THRESH;
      step_r <= `SSM_RST_STEP;
      window_r <= `SSM_RST_WINDOW;
      trim_r <= `SSM_RST_TRIM;
      pinSel_r <= '0;
      slotSel_r <= 8'h00;
    end else begin
      cfg_r <= cfg_nxt;
      thresh_r <= thresh_nxt;
      step_r <= step_nxt;
      window_r <= window_nxt;
      trim_r <= trim_nxt;
      pinSel_r <= pinSel_nxt;
      slotSel_r <= slotSel_nxt;
    end
  end

  // ==========================================================
  // measurement, latch, threshold and jump detection
  always_comb begin
    logic [9:0] sum;
    logic [8:0] hi, lo;
    sum = acc_r + {2'b00, chanPower};
    hi = 9'h000;
    lo = 9'h000;
    strength_nxt = strength_r;
    acc_nxt = acc_r;
    phase_nxt = phase_r;
    upd = 1'b0;
    bitCnt_nxt = bitCnt_r;
    latched_nxt = latched_r;
    latchDone_nxt = latchDone_r;
    pend_nxt = pend_r;
    hist_nxt = hist_r;
    histCnt_nxt = histCnt_r;
    jumpEvt_nxt = 1'b0;
    minBits = cfg_r.avg4 ? `SSM_MIN_BITS_AVG : `SSM_MIN_BITS;
    win = (window_r == 4'h0) ? 4'h1 : window_r;
    old = hist_r[win - 4'h1];
    if (bitTick) begin
      bitCnt_nxt = (bitCnt_r == 8'hFF) ? bitCnt_r : bitCnt_r + 8'h01;
      if (!cfg_r.avg4) begin
        strength_nxt = chanPower;
        upd = 1'b1;
      end else if (phase_r == 2'b11) begin
        strength_nxt = sum[9:2];
        acc_nxt = 10'h000;
        phase_nxt = 2'b00;
        upd = 1'b1;
      end else begin
        acc_nxt = sum;
        phase_nxt = phase_r + 2'b01;
      end
    end
    if ((cfg_r.latchMode == SSM_LATCH_PREAMBLE && preambleDet) ||
        (cfg_r.latchMode == SSM_LATCH_SYNC && syncDet)) begin
      pend_nxt = 1'b1;
    end
    // early events wait until the modem has settled
    trig = (pend_r || (cfg_r.latchMode == SSM_LATCH_BITCOUNT && bitCnt_r >= cfg_r.latchBits))
           && bitCnt_r >= minBits;
    if (!latchDone_r && trig && rxActive) begin
      latched_nxt = strength_r;
      latchDone_nxt = 1'b1;
    end
    if (upd) begin
      for (int i = HDEPTH - 1; i > 0; i--) begin
        hist_nxt[i] = hist_r[i-1];
      end
      hist_nxt[0] = strength_nxt;
      histCnt_nxt = (histCnt_r == 4'hF) ? histCnt_r : histCnt_r + 4'h1;
      hi = {1'b0, strength_nxt};
      lo = {1'b0, old} + {1'b0, step_r};
      // slope test: step must appear within the window, slow drift never does
      if (histCnt_r >= win) begin
        jumpEvt_nxt = (cfg_r.jumpUp && hi > lo) ||
                      (cfg_r.jumpDn && {1'b0, old} > hi + {1'b0, step_r});
      end
    end
    if (rxStart) begin
      latched_nxt = 8'h00;
      latchDone_nxt = 1'b0;
      pend_nxt = 1'b0;
      bitCnt_nxt = 8'h00;
      acc_nxt = 10'h000;
      phase_nxt = 2'b00;
      histCnt_nxt = 4'h0;
    end
    above_nxt = strength_r > thresh_r;
    aboveLat_nxt = (above_r && rxActive) || (aboveLat_r && !stClr[1] && !rxStart);
    jumpSeen_nxt = jumpEvt_r || (jumpSeen_r && !stClr[2]);
    rstOut_nxt = jumpEvt_r && cfg_r.jumpRst;
    for (int g = 0; g < NGPIO; g++) begin
      case (ssm_pin_src_t'(pinSel_r[2*g +: 2]))
        SSM_PIN_ABOVE:    gpio_nxt[g] = above_r;
        SSM_PIN_ABOVELAT: gpio_nxt[g] = aboveLat_r;
        SSM_PIN_JUMP:     gpio_nxt[g] = jumpSeen_r;
        default:          gpio_nxt[g] = 1'b0;
      endcase
    end
    qState_nxt = qState_r;
    qCnt_nxt = qCnt_r;
    qResp_nxt = qResp_r;
    if (queryGo) begin
      qState_nxt = SSM_Q_BUSY;
      qCnt_nxt = 12'(QUERY_CYC);
      qResp_nxt = {latched_r, strength_r};
    end else if (qState_r == SSM_Q_BUSY) begin
      qCnt_nxt = qCnt_r - 12'h001;
      if (qCnt_r == 12'h001) begin
        qState_nxt = SSM_Q_IDLE;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bitS1_r <= 1'b0;
      bitS2_r <= 1'b0;
      bitS3_r <= 1'b0;
      rxPrev_r <= 1'b0;
      strength_r <= 8'h00;
      acc_r <= 10'h000;
      phase_r <= 2'b00;
      bitCnt_r <= 8'h00;
      latched_r <= 8'h00;
      latchDone_r <= 1'b0;
      pend_r <= 1'b0;
      histCnt_r <= 4'h0;
      for (int i = 0; i < HDEPTH; i++) begin
        hist_r[i] <= 8'h00;
      end
      above_r <= 1'b0;
      aboveLat_r <= 1'b0;
      jumpSeen_r <= 1'b0;
      jumpEvt_r <= 1'b0;
      rstOut_r <= 1'b0;
      gpio_r <= '0;
      qState_r <= SSM_Q_IDLE;
      qCnt_r <= 12'h000;
      qResp_r <= 16'h0000;
    end else begin
      bitS1_r <= bitClk;
      bitS2_r <= bitS1_r;
      bitS3_r <= bitS2_r;
      rxPrev_r <= rxActive;
      strength_r <= strength_nxt;
      acc_r <= acc_nxt;
      phase_r <= phase_nxt;
      bitCnt_r <= bitCnt_nxt;
      latched_r <= latched_nxt;
      latchDone_r <= latchDone_nxt;
      pend_r <= pend_nxt;
      histCnt_r <= histCnt_nxt;
      hist_r <= hist_nxt;
      above_r <= above_nxt;
      aboveLat_r <= aboveLat_nxt;
      jumpSeen_r <= jumpSeen_nxt;
      jumpEvt_r <= jumpEvt_nxt;
      rstOut_r <= rstOut_nxt;
      gpio_r <= gpio_nxt;
      qState_r <= qState_nxt;
      qCnt_r <= qCnt_nxt;
      qResp_r <= qResp_nxt;
    end
  end

  assign gpioOut = gpio_r;
  assign aboveIrq = above_r;
  assign jumpIrq = jumpEvt_r;
  assign rxRestart = rstOut_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_clearAtEntry;
    rxStart |=> latched_r == 8'h00 && !latchDone_r;
  endproperty
  a_clearAtEntry: assert property (p_clearAtEntry) else $error("latch not cleared");

  property p_holdLatched;
    latchDone_r && !rxStart |=> $stable(latched_r);
  endproperty
  a_holdLatched: assert property (p_holdLatched) else $error("latched value moved");

  property p_minFour;
    $rose(latchDone_r) |-> $past(bitCnt_r) >= 8'h04;
  endproperty
  a_minFour: assert property (p_minFour) else $error("latched before four bits");

  property p_minSeven;
    $rose(latchDone_r) && $past(cfg_r.avg4) |-> $past(bitCnt_r) >= 8'h07;
  endproperty
  a_minSeven: assert property (p_minSeven) else $error("averaged latch too early");

  property p_avgUpdate;
    $changed(strength_r) && cfg_r.avg4 && $stable(cfg_r.avg4) |-> $past(phase_r) == 2'b11;
  endproperty
  a_avgUpdate: assert property (p_avgUpdate) else $error("average updated off grid");

  property p_pinAbove;
    pinSel_r[3:2] == 2'b01 && strength_r > thresh_r && $stable(pinSel_r) ##1 $stable(pinSel_r)
      |=> gpioOut[1];
  endproperty
  a_pinAbove: assert property (p_pinAbove) else $error("threshold not on pin");

  property p_restart;
    jumpEvt_r && cfg_r.jumpRst |=> rxRestart ##1 !rxRestart || jumpEvt_r;
  endproperty
  a_restart: assert property (p_restart) else $error("restart missing");

  property p_jumpEnabled;
    jumpEvt_r |-> $past(cfg_r.jumpUp) || $past(cfg_r.jumpDn);
  endproperty
  a_jumpEnabled: assert property (p_jumpEnabled) else $error("jump while disabled");

  property p_queryBusy;
    queryGo |=> qState_r == SSM_Q_BUSY [*8];
  endproperty
  a_queryBusy: assert property (p_queryBusy) else $error("query ready too early");

endmodule

/* File: common/ssm_params.svh */
// offsets, field positions, reset values and timing counts of the strength monitor
// assumes a 32-bit AXI4-Lite register bus with byte addresses
`ifndef SSM_PARAMS_SVH
`define SSM_PARAMS_SVH

// ==========================================================
// register byte offsets
`define SSM_OFF_CONFIG    8'h00
`define SSM_OFF_THRESH    8'h04
`define SSM_OFF_STEP      8'h08
`define SSM_OFF_WINDOW    8'h0C
`define SSM_OFF_TRIM      8'h10
`define SSM_OFF_GPIOSEL   8'h14
`define SSM_OFF_CURRENT   8'h18
`define SSM_OFF_LATCHED   8'h1C
`define SSM_OFF_STATUS    8'h20
`define SSM_OFF_SLOTSEL   8'h24
`define SSM_OFF_SLOT0     8'h28
`define SSM_OFF_QUERY     8'h38
`define SSM_OFF_RESP      8'h3C

// ==========================================================
// config register fields
`define SSM_CFG_MODE_LSB  0
`define SSM_CFG_AVG_BIT   2
`define SSM_CFG_BITS_LSB  8
`define SSM_CFG_UP_BIT    16
`define SSM_CFG_DN_BIT    17
`define SSM_CFG_RST_BIT   18
// status register fields
`define SSM_ST_ABOVE_BIT  0
`define SSM_ST_ABLAT_BIT  1
`define SSM_ST_JUMP_BIT   2
`define SSM_ST_CTS_BIT    3
`define SSM_ST_DONE_BIT   4

// ==========================================================
// reset values
`define SSM_RST_THRESH    8'hFF
`define SSM_RST_STEP      8'h0C
`define SSM_RST_WINDOW    4'h4
`define SSM_RST_TRIM      8'h40
`define SSM_RST_BITS      8'h04

// ==========================================================
// timing
`define SSM_MIN_BITS      8'h04
`define SSM_MIN_BITS_AVG  8'h07
`define SSM_CLK_NS        20
`define SSM_QUERY_NS      33000

`endif

/* File: common/ssm_pkg.sv */
// types shared by the strength monitor
// assumes ssm_params.svh supplies the numeric constants
package ssm_pkg;

  typedef enum logic [1:0] {
    SSM_LATCH_PREAMBLE = 2'b00,
    SSM_LATCH_SYNC     = 2'b01,
    SSM_LATCH_BITCOUNT = 2'b10,
    SSM_LATCH_NONE     = 2'b11
  } ssm_latch_mode_t;

  typedef enum logic [1:0] {
    SSM_SRC_NONE     = 2'b00,
    SSM_SRC_LATCHED  = 2'b01,
    SSM_SRC_CURRENT  = 2'b10,
    SSM_SRC_STATUS   = 2'b11
  } ssm_slot_src_t;

  typedef enum logic [1:0] {
    SSM_PIN_LOW      = 2'b00,
    SSM_PIN_ABOVE    = 2'b01,
    SSM_PIN_ABOVELAT = 2'b10,
    SSM_PIN_JUMP     = 2'b11
  } ssm_pin_src_t;

  typedef enum logic [0:0] {
    SSM_Q_IDLE = 1'b0,
    SSM_Q_BUSY = 1'b1
  } ssm_query_state_t;

  typedef struct packed {
    logic jumpRst;
    logic jumpDn;
    logic jumpUp;
    logic [7:0] latchBits;
    logic avg4;
    ssm_latch_mode_t latchMode;
  } ssm_cfg_t;

endpackage

/* File: bench/ssm_modem_model.sv */
// modem-side model: bit clock, receive window and filtered power level
// assumes the bench requests receive mode and power on ref_clk
`timescale 1ns/1ps
module ssm_modem_model (
  // bench requests
  input wire logic ref_clk,
  input wire logic rxReq,
  input wire logic [7:0] powReq,
  // monitor side
  output logic bitClk,
  output logic rxActive,
  output logic [7:0] chanPower
);
  // power is already channel filtered, half-dB per count
  always @(posedge ref_clk) begin
    rxActive <= rxReq;
    chanPower <= powReq;
  end
  // own phase; stands low outside receive frames
  initial begin
    bitClk = 1'b0;
    #7;
    forever begin
      #80;
      bitClk = rxActive ? ~bitClk : 1'b0;
    end
  end
endmodule

/* File: bench/signal_strength_monitor_test.sv */
// self-checking bench for the strength monitor over axi4-lite
// assumes ssm_params.svh on the include path and ssm_modem_model
`timescale 1ns/1ps
`include "ssm_params.svh"
module signal_strength_monitor_test;
  import ssm_pkg::*;
  logic ref_clk, rst_b, rxReq, preambleDet, syncDet, bitClk, rxActive;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic aboveIrq, jumpIrq, rxRestart;
  logic [7:0] s_axi_awaddr, s_axi_araddr, powReq, chanPower, p, t, expL;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb, gpioOut;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  int errors, n_checks, cyc, nJump, nRst, n0;

  signal_strength_monitor uut (.ref_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .chanPower, .bitClk, .rxActive, .preambleDet, .syncDet, .gpioOut, .aboveIrq,
    .jumpIrq, .rxRestart);
  ssm_modem_model modem (.ref_clk, .rxReq, .powReq, .bitClk, .rxActive, .chanPower);

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // ====
  // event counters and hang limit
  always @(posedge ref_clk) begin
    cyc++;
    nJump += (jumpIrq === 1'b1);
    nRst += (rxRestart === 1'b1);
    if (cyc == 60000) begin
      errors++;
      end_sim();
    end
  end
  // ====
  // helpers
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge ref_clk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask
  // margin covers sync delay plus the update edge
  task automatic ticks(input int n);
    repeat (n) @(posedge bitClk);
    repeat (6) @(posedge ref_clk);
  endtask
  // host view: level = count/2 - trim - 70, solved for the count
  function automatic logic [7:0] dbm2cnt(input int lvl, input int trim);
    return 8'(2 * (lvl + trim + 70));
  endfunction
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ====
  // main sequence
  initial begin
    {rst_b, rxReq, preambleDet, syncDet, powReq} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    void'($urandom(62));
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rc(`SSM_OFF_CONFIG, 32'h0000_0400);
    rc(`SSM_OFF_THRESH, 32'h0000_00FF);
    rc(`SSM_OFF_STEP, 32'h0000_000C);
    rc(`SSM_OFF_WINDOW, 32'h0000_0004);
    rc(`SSM_OFF_TRIM, 32'h0000_0040);
    rc(`SSM_OFF_STATUS, 32'h0000_0008);
    rc(`SSM_OFF_LATCHED, 32'h0000_0000);
    rd(8'h40);
    chk({rdat[29:0], resp}, 32'h0000_0002);
    wr(8'h44, 32'h0000_0001);
    chk({30'h0, resp}, 32'h0000_0002);
    $display("test reset done");
    // every latch event, with and without averaging
    for (int i = 0; i < 8; i++) begin
      p = dbm2cnt(int'($urandom_range(1, 126)) - 134, `SSM_RST_TRIM);
      expL = (i % 4 == 3) ? 8'h00 : p;
      powReq <= p;
      wr(`SSM_OFF_CONFIG, 32'((i % 4) | ((i / 4) << 2) | (5 << 8)));
      wr(`SSM_OFF_SLOTSEL, 32'h0000_00E4);
      rxReq <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rc(`SSM_OFF_LATCHED, 32'h0000_0000);
      ticks(2);
      preambleDet <= (i % 4 == 0);
      syncDet <= (i % 4 == 1);
      @(posedge ref_clk);
      preambleDet <= 1'b0;
      syncDet <= 1'b0;
      ticks(10);
      rc(`SSM_OFF_LATCHED, {24'h0, expL});
      powReq <= ~p;
      ticks(9);
      rc(`SSM_OFF_CURRENT, {24'h0, ~p});
      rxReq <= 1'b0;
      repeat (20) @(posedge ref_clk);
      rc(`SSM_OFF_LATCHED, {24'h0, expL});
      rc(`SSM_OFF_SLOT0, 32'h0000_0000);
      rc(`SSM_OFF_SLOT0 + 8'h04, {24'h0, expL});
      rc(`SSM_OFF_SLOT0 + 8'h08, {24'h0, ~p});
      rc(`SSM_OFF_SLOT0 + 8'h0C, (i % 4 == 3) ? 32'h0000_0008 : 32'h0000_0018);
      wr(`SSM_OFF_QUERY, 32'h0000_0001);
      rc(`SSM_OFF_RESP, {16'h0, expL, ~p});
      repeat (1600) @(posedge ref_clk);
      rd(`SSM_OFF_STATUS);
      chk(rdat & 32'h0000_0008, 32'h0000_0000);
      repeat (60) @(posedge ref_clk);
      rd(`SSM_OFF_STATUS);
      chk(rdat & 32'h0000_0008, 32'h0000_0008);
    end
    $display("test latch done");
    // threshold edge and pin routing
    t = 8'($urandom_range(0, 240));
    powReq <= t;
    wr(`SSM_OFF_CONFIG, 32'h0000_0003);
    wr(`SSM_OFF_THRESH, {24'h0, t});
    wr(`SSM_OFF_WINDOW, 32'h0000_0001);
    wr(`SSM_OFF_STEP, 32'h0000_0008);
    wr(`SSM_OFF_GPIOSEL, 32'h0000_00E4);
    rxReq <= 1'b1;
    ticks(4);
    chk({31'h0, aboveIrq}, 32'h0000_0000);
    powReq <= t + 8'h01;
    ticks(2);
    chk({27'h0, aboveIrq, gpioOut}, 32'h0000_0016);
    powReq <= t;
    ticks(2);
    chk({28'h0, gpioOut}, 32'h0000_0004);
    wr(`SSM_OFF_STATUS, 32'h0000_0002);
    repeat (2) @(posedge ref_clk);
    chk({28'h0, gpioOut}, 32'h0000_0000);
    $display("test threshold done");
    // jump detect, armed only once the signal is settled
    powReq <= 8'h80;
    ticks(3);
    wr(`SSM_OFF_CONFIG, 32'h0007_0003);
    n0 = nJump;
    powReq <= 8'h88;
    ticks(3);
    chk(32'(nJump), 32'(n0));
    powReq <= 8'h91;
    ticks(3);
    chk(32'(nJump), 32'(n0 + 1));
    chk({31'h0, gpioOut[3]}, 32'h0000_0001);
    powReq <= 8'h88;
    ticks(3);
    chk(32'(nJump), 32'(n0 + 2));
    chk(32'(nRst), 32'h0000_0002);
    rxReq <= 1'b0;
    $display("test jump done");
    end_sim();
  end
endmodule
